/* shared/cdu_pkg.sv */
// Purpose: constants and types of the conversion and dac update config bank
// Assumes: 125 MHz core clock, byte-wide register port
// Notes: reserved bits are masked off on write and read back as zero
package cdu_pkg;
    // register addresses
    localparam logic [7:0] ADDR_DAC_A = 8'h11;
    localparam logic [7:0] ADDR_DAC_B = 8'h13;
    localparam logic [7:0] ADDR_DAC_C = 8'h15;
    localparam logic [7:0] ADDR_DAC_D = 8'h17;
    localparam logic [7:0] ADDR_CONV_CTRL = 8'h19;
    localparam logic [7:0] ADDR_SRC_CTRL = 8'h1a;
    localparam logic [7:0] ADDR_DAC_CFG = 8'h1b;
    localparam logic [7:0] ADDR_LOAD_REG = 8'h1c;
    // reset value and writable-bit masks
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MASK_CONV = 8'h77;
    localparam logic [7:0] MASK_SRC = 8'h79;
    localparam logic [7:0] MASK_DAC = 8'h3f;
    localparam logic [7:0] RD_NONE = 8'h00;
    // field positions
    localparam int CC_CHAN_MSB = 2;
    localparam int CC_SINGLE = 4;
    localparam int CC_AVG_OFF = 5;
    localparam int CC_TIMEOUT = 6;
    localparam int CC_SOFT_RST = 7;
    localparam int SC_FAST = 0;
    localparam int SC_UPD_SRC = 3;
    localparam int SC_REF_VDD = 4;
    localparam int SC_TRACK_A = 5;
    localparam int SC_TRACK_B = 6;
    localparam int DC_RANGE_MSB = 3;
    localparam int DC_MODE_LSB = 4;
    localparam int DC_MODE_MSB = 5;
    localparam int LR_LOAD_MSB = 3;
    // channel codes
    localparam logic [2:0] CH_VDD = 3'h0;
    localparam logic [2:0] CH_INT_TEMP = 3'h1;
    localparam logic [2:0] CH_EXT_ANALOG_INPUT_ONE = 3'h2;
    localparam logic [2:0] CH_ANALOG_INPUT_TWO = 3'h3;
    localparam logic [2:0] CH_ANALOG_INPUT_THREE = 3'h4;
    localparam logic [2:0] CH_LAST = 3'h5;
    // input pair codes
    localparam logic [1:0] PAIR_EXT_TEMP = 2'h2;
    // load modes and load masks
    localparam logic [1:0] LM_SINGLE = 2'h0;
    localparam logic [1:0] LM_PAIR = 2'h1;
    localparam logic [1:0] LM_ALL = 2'h2;
    localparam logic [1:0] LM_REG = 2'h3;
    localparam logic [3:0] LD_NONE = 4'h0;
    localparam logic [3:0] LD_A = 4'h1;
    localparam logic [3:0] LD_B = 4'h2;
    localparam logic [3:0] LD_C = 4'h4;
    localparam logic [3:0] LD_D = 4'h8;
    localparam logic [3:0] LD_AB = 4'h3;
    localparam logic [3:0] LD_CD = 4'hc;
    localparam logic [3:0] LD_ALL = 4'hf;
    // averaging
    localparam int AVG_CONV = 16;
    localparam logic [3:0] AVG_LAST = 4'(AVG_CONV - 1);
    localparam logic [3:0] AVG_ZERO = 4'h0;
    localparam logic [3:0] AVG_STEP = 4'h1;
    // timing
    localparam int CLK_HZ = 125_000_000;
    localparam real ADC_SLOW_KHZ = 1.4;
    localparam real ADC_FAST_KHZ = 22.5;
    localparam int SCL_TMO_MS = 25;
    localparam int ADC_SLOW_DIV = int'($floor(CLK_HZ / (ADC_SLOW_KHZ * 1000.0)));
    localparam int ADC_FAST_DIV = int'($floor(CLK_HZ / (ADC_FAST_KHZ * 1000.0)));
    localparam int SCL_TMO_CYC = SCL_TMO_MS * (CLK_HZ / 1000);
    localparam int DIV_W = 17;
    localparam int TMO_W = 22;
    // conversion sequencer states
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_START = 3'b010,
        SQ_WAIT = 3'b100
    } cdu_seq_t;
endpackage

/* rtl/cdu_tick_div.sv */
// Purpose: adc conversion clock tick generator
// Assumes: reload values are at least two cycles
// Notes: a speed change takes effect at the next wrap
`timescale 1ns/1ps
module cdu_tick_div #(
    parameter int SLOW_DIV = cdu_pkg::ADC_SLOW_DIV,
    parameter int FAST_DIV = cdu_pkg::ADC_FAST_DIV
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // control and tick
    input wire logic i_fast,
    output logic o_tick
);
    localparam int W = cdu_pkg::DIV_W;
    localparam logic [W-1:0] SLOW_LOAD = W'(SLOW_DIV - 1);
    localparam logic [W-1:0] FAST_LOAD = W'(FAST_DIV - 1);
    localparam logic [W-1:0] CNT_ZERO = W'(0);
    localparam logic [W-1:0] CNT_STEP = W'(1);

    logic [W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= CNT_ZERO;
            tick_ff <= 1'b0;
        end else if (i_ce) begin
            tick_ff <= (cnt_ff == CNT_ZERO);
            if (cnt_ff == CNT_ZERO) begin
                cnt_ff <= i_fast ? FAST_LOAD : SLOW_LOAD;
            end else begin
                cnt_ff <= cnt_ff - CNT_STEP;
            end
        end
    end

    assign o_tick = tick_ff;
endmodule

/* rtl/cdu_low_watch.sv */
// Purpose: flags a line held low longer than a limit
// Assumes: line is synchronous to the clock
// Notes: flag drops as soon as the line is high or watching is off
`timescale 1ns/1ps
module cdu_low_watch #(
    parameter int LIMIT = cdu_pkg::SCL_TMO_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // line and flag
    input wire logic i_enable,
    input wire logic i_level,
    output logic o_expired
);
    localparam int W = cdu_pkg::TMO_W;
    localparam logic [W-1:0] CNT_LIM = W'(LIMIT - 1);
    localparam logic [W-1:0] CNT_ZERO = W'(0);
    localparam logic [W-1:0] CNT_STEP = W'(1);

    logic [W-1:0] cnt_ff;
    logic expired_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= CNT_ZERO;
            expired_ff <= 1'b0;
        end else if (i_ce) begin
            if (!i_enable || i_level) begin
                cnt_ff <= CNT_ZERO;
                expired_ff <= 1'b0;
            end else if (cnt_ff == CNT_LIM) begin
                expired_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + CNT_STEP;
            end
        end
    end

    assign o_expired = expired_ff;
endmodule

/* rtl/cdu_bank.sv */
// Purpose: conversion and dac update configuration bank with sequencer
// Assumes: register port is the decoded serial interface access
// Notes: first control register bits arrive as plain inputs
`timescale 1ns/1ps
module cdu_bank #(
    parameter int SLOW_DIV = cdu_pkg::ADC_SLOW_DIV,
    parameter int FAST_DIV = cdu_pkg::ADC_FAST_DIV,
    parameter int SCL_TMO = cdu_pkg::SCL_TMO_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // register port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // first control register fields
    input wire logic i_monitor_en,
    input wire logic [1:0] i_pair_sel,
    // pins
    input wire logic i_dac_load_strobe_n,
    input wire logic i_scl,
    output logic o_scl_release,
    // converter handshake
    input wire logic i_conv_done,
    output logic o_conv_start,
    output logic [2:0] o_conv_chan,
    output logic o_conv_ext_temp,
    output logic o_result_store,
    // analog settings
    output logic o_avg_disable,
    output logic o_fast_clk,
    output logic o_filter_off,
    output logic o_ref_vdd,
    output logic [3:0] o_dac_range,
    output logic o_soft_reset,
    // dac codes and loads
    input wire logic [7:0] i_dac_a_code,
    input wire logic [7:0] i_dac_b_code,
    input wire logic [7:0] i_int_temp_code,
    input wire logic [7:0] i_ext_temp_code,
    output logic [7:0] o_dac_a_value,
    output logic [7:0] o_dac_b_value,
    output logic [3:0] o_dac_load
);
    logic [7:0] conv_ctrl_ff;
    logic [7:0] src_ctrl_ff;
    logic [7:0] dac_cfg_ff;
    logic [7:0] rdata_ff;
    logic soft_rst_ff;
    logic soft_wr;
    logic [3:0] load_ff;
    logic [3:0] nxt_load;
    logic pin_q_ff;
    logic [7:0] dac_a_ff;
    logic [7:0] dac_b_ff;
    cdu_pkg::cdu_seq_t state_ff;
    logic [2:0] rr_chan_ff;
    logic [3:0] avg_cnt_ff;
    logic [2:0] chan_ff;
    logic ext_ff;
    logic store_ff;
    logic tick;
    logic single;
    logic ext_sel;
    logic [2:0] cfg_chan;
    logic [2:0] cur_chan;
    logic chan_legal;
    logic [3:0] avg_last;
    logic [1:0] load_mode;
    logic pin_fall;

    function automatic logic [2:0] next_rr(input logic [2:0] c,
                                           input logic ext);
        logic [2:0] n;
        n = (c >= cdu_pkg::CH_LAST) ? cdu_pkg::CH_VDD : c + 3'h1;
        // second input shares its pin with the diode
        if (ext && n == cdu_pkg::CH_ANALOG_INPUT_TWO) begin
            n = cdu_pkg::CH_ANALOG_INPUT_THREE;
        end
        return n;
    endfunction

    assign soft_wr = i_wr_en && i_addr == cdu_pkg::ADDR_CONV_CTRL &&
                     i_wdata[cdu_pkg::CC_SOFT_RST];
    assign single = conv_ctrl_ff[cdu_pkg::CC_SINGLE];
    assign cfg_chan = conv_ctrl_ff[cdu_pkg::CC_CHAN_MSB:0];
    assign ext_sel = i_pair_sel == cdu_pkg::PAIR_EXT_TEMP;
    assign load_mode = dac_cfg_ff[cdu_pkg::DC_MODE_MSB:cdu_pkg::DC_MODE_LSB];

    // register storage; soft reset write clears instead of storing
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_ctrl_ff <= cdu_pkg::REG_RST;
            src_ctrl_ff <= cdu_pkg::REG_RST;
            dac_cfg_ff <= cdu_pkg::REG_RST;
        end else if (i_ce) begin
            if (soft_wr) begin
                conv_ctrl_ff <= cdu_pkg::REG_RST;
                src_ctrl_ff <= cdu_pkg::REG_RST;
                dac_cfg_ff <= cdu_pkg::REG_RST;
            end else if (i_wr_en) begin
                unique case (i_addr)
                    cdu_pkg::ADDR_CONV_CTRL: begin
                        // soft reset bit never stored
                        conv_ctrl_ff <= i_wdata & cdu_pkg::MASK_CONV;
                    end
                    cdu_pkg::ADDR_SRC_CTRL: begin
                        src_ctrl_ff <= i_wdata & cdu_pkg::MASK_SRC;
                    end
                    cdu_pkg::ADDR_DAC_CFG: begin
                        dac_cfg_ff <= i_wdata & cdu_pkg::MASK_DAC;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // soft reset pulse toward dac outputs and the rest of the device
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            soft_rst_ff <= 1'b0;
        end else if (i_ce) begin
            soft_rst_ff <= soft_wr;
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= cdu_pkg::RD_NONE;
        end else if (i_ce && i_rd_en) begin
            unique case (i_addr)
                cdu_pkg::ADDR_CONV_CTRL: rdata_ff <= conv_ctrl_ff;
                cdu_pkg::ADDR_SRC_CTRL: rdata_ff <= src_ctrl_ff;
                cdu_pkg::ADDR_DAC_CFG: rdata_ff <= dac_cfg_ff;
                default: rdata_ff <= cdu_pkg::RD_NONE;
            endcase
        end
    end

    // load command generation
    assign pin_fall = pin_q_ff && !i_dac_load_strobe_n;

    always_comb begin
        nxt_load = cdu_pkg::LD_NONE;
        if (!src_ctrl_ff[cdu_pkg::SC_UPD_SRC]) begin
            if (pin_fall) begin
                nxt_load = cdu_pkg::LD_ALL;
            end
        end else if (i_wr_en) begin
            unique case (load_mode)
                cdu_pkg::LM_SINGLE: begin
                    unique case (i_addr)
                        cdu_pkg::ADDR_DAC_A: nxt_load = cdu_pkg::LD_A;
                        cdu_pkg::ADDR_DAC_B: nxt_load = cdu_pkg::LD_B;
                        cdu_pkg::ADDR_DAC_C: nxt_load = cdu_pkg::LD_C;
                        cdu_pkg::ADDR_DAC_D: nxt_load = cdu_pkg::LD_D;
                        default: nxt_load = cdu_pkg::LD_NONE;
                    endcase
                end
                cdu_pkg::LM_PAIR: begin
                    if (i_addr == cdu_pkg::ADDR_DAC_B) begin
                        nxt_load = cdu_pkg::LD_AB;
                    end else if (i_addr == cdu_pkg::ADDR_DAC_D) begin
                        nxt_load = cdu_pkg::LD_CD;
                    end
                end
                cdu_pkg::LM_ALL: begin
                    if (i_addr == cdu_pkg::ADDR_DAC_D) begin
                        nxt_load = cdu_pkg::LD_ALL;
                    end
                end
                cdu_pkg::LM_REG: begin
                    if (i_addr == cdu_pkg::ADDR_LOAD_REG) begin
                        nxt_load = i_wdata[cdu_pkg::LR_LOAD_MSB:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            load_ff <= cdu_pkg::LD_NONE;
            pin_q_ff <= 1'b1;
        end else if (i_ce) begin
            load_ff <= nxt_load;
            pin_q_ff <= i_dac_load_strobe_n;
        end
    end

    // temperature tracking on the first two dacs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dac_a_ff <= cdu_pkg::REG_RST;
            dac_b_ff <= cdu_pkg::REG_RST;
        end else if (i_ce) begin
            dac_a_ff <= src_ctrl_ff[cdu_pkg::SC_TRACK_A] ?
                        i_int_temp_code : i_dac_a_code;
            dac_b_ff <= src_ctrl_ff[cdu_pkg::SC_TRACK_B] ?
                        i_ext_temp_code : i_dac_b_code;
        end
    end

    // conversion clock and bus timeout
    cdu_tick_div #(
        .SLOW_DIV(SLOW_DIV),
        .FAST_DIV(FAST_DIV)
    ) u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_fast(src_ctrl_ff[cdu_pkg::SC_FAST]),
        .o_tick(tick)
    );

    cdu_low_watch #(
        .LIMIT(SCL_TMO)
    ) u_scl (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_enable(conv_ctrl_ff[cdu_pkg::CC_TIMEOUT]),
        .i_level(i_scl),
        .o_expired(o_scl_release)
    );

    // conversion sequencer
    assign cur_chan = single ? cfg_chan : rr_chan_ff;
    assign chan_legal = cur_chan <= cdu_pkg::CH_LAST;
    assign avg_last = conv_ctrl_ff[cdu_pkg::CC_AVG_OFF] ?
                      cdu_pkg::AVG_ZERO : cdu_pkg::AVG_LAST;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= cdu_pkg::SQ_IDLE;
            rr_chan_ff <= cdu_pkg::CH_VDD;
            avg_cnt_ff <= cdu_pkg::AVG_ZERO;
            chan_ff <= cdu_pkg::CH_VDD;
            ext_ff <= 1'b0;
            store_ff <= 1'b0;
        end else if (i_ce) begin
            store_ff <= 1'b0;
            unique case (state_ff)
                cdu_pkg::SQ_IDLE: begin
                    if (!i_monitor_en) begin
                        avg_cnt_ff <= cdu_pkg::AVG_ZERO;
                    end else if (tick && chan_legal) begin
                        state_ff <= cdu_pkg::SQ_START;
                        chan_ff <= cur_chan;
                        ext_ff <= ext_sel && cur_chan == cdu_pkg::CH_EXT_ANALOG_INPUT_ONE;
                    end
                end
                cdu_pkg::SQ_START: begin
                    state_ff <= cdu_pkg::SQ_WAIT;
                end
                cdu_pkg::SQ_WAIT: begin
                    if (!i_monitor_en) begin
                        state_ff <= cdu_pkg::SQ_IDLE;
                        avg_cnt_ff <= cdu_pkg::AVG_ZERO;
                    end else if (i_conv_done) begin
                        state_ff <= cdu_pkg::SQ_IDLE;
                        if (avg_cnt_ff >= avg_last) begin
                            avg_cnt_ff <= cdu_pkg::AVG_ZERO;
                            store_ff <= 1'b1;
                            rr_chan_ff <= next_rr(rr_chan_ff, ext_sel);
                        end else begin
                            avg_cnt_ff <= avg_cnt_ff + cdu_pkg::AVG_STEP;
                        end
                    end
                end
                default: state_ff <= cdu_pkg::SQ_IDLE;
            endcase
        end
    end

    // outputs
    assign o_rdata = rdata_ff;
    assign o_conv_start = state_ff == cdu_pkg::SQ_START;
    assign o_conv_chan = chan_ff;
    assign o_conv_ext_temp = ext_ff;
    assign o_result_store = store_ff;
    assign o_avg_disable = conv_ctrl_ff[cdu_pkg::CC_AVG_OFF];
    assign o_fast_clk = src_ctrl_ff[cdu_pkg::SC_FAST];
    assign o_filter_off = src_ctrl_ff[cdu_pkg::SC_FAST];
    assign o_ref_vdd = src_ctrl_ff[cdu_pkg::SC_REF_VDD];
    assign o_dac_range = dac_cfg_ff[cdu_pkg::DC_RANGE_MSB:0];
    assign o_soft_reset = soft_rst_ff;
    assign o_dac_a_value = dac_a_ff;
    assign o_dac_b_value = dac_b_ff;
    assign o_dac_load = load_ff;

    // checks
    soft_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && soft_wr |=> o_soft_reset && conv_ctrl_ff == 8'h00 &&
        src_ctrl_ff == 8'h00 && dac_cfg_ff == 8'h00)
        else $error("soft reset did not clear registers");
    self_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_rd_en && i_addr == cdu_pkg::ADDR_CONV_CTRL |=> !o_rdata[7])
        else $error("soft reset bit read back set");
    reserved_chan_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == cdu_pkg::SQ_IDLE && single && cfg_chan > 3'h5
        |=> !o_conv_start)
        else $error("reserved channel started a conversion");
    monitor_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == cdu_pkg::SQ_IDLE && !i_monitor_en |=> !o_conv_start)
        else $error("conversion started while monitoring off");
    single_chan_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == cdu_pkg::SQ_IDLE && i_monitor_en && tick &&
        single && chan_legal
        |=> o_conv_start && o_conv_chan == $past(cfg_chan))
        else $error("single channel start or code wrong");
    ext_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == cdu_pkg::SQ_IDLE && i_monitor_en && tick &&
        chan_legal |=> o_conv_ext_temp ==
        $past(i_pair_sel == 2'h2 && cur_chan == 3'h2))
        else $error("diode or first input selection wrong");
    avg_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_result_store) |->
        $past(avg_cnt_ff) == ($past(o_avg_disable) ? 4'h0 : 4'hf))
        else $error("result stored after wrong number of conversions");
    load_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_wr_en && src_ctrl_ff[3] && load_mode == 2'h0 &&
        i_addr == cdu_pkg::ADDR_DAC_B |=> o_dac_load == 4'h2)
        else $error("single load mode loaded wrong dacs");
    load_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_wr_en && src_ctrl_ff[3] && load_mode == 2'h1 &&
        i_addr == cdu_pkg::ADDR_DAC_D |=> o_dac_load == 4'hc)
        else $error("pair load mode loaded wrong dacs");
    load_all_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_wr_en && src_ctrl_ff[3] && load_mode == 2'h2 &&
        i_addr == cdu_pkg::ADDR_DAC_D |=> o_dac_load == 4'hf)
        else $error("all load mode did not load four dacs");
    load_reg_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_wr_en && src_ctrl_ff[3] && load_mode == 2'h3 &&
        i_addr[7:4] == 4'h1 && i_addr[0] |=> o_dac_load == 4'h0)
        else $error("dac write loaded in register mode");
    pin_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !src_ctrl_ff[3] && pin_q_ff && !i_dac_load_strobe_n
        |=> o_dac_load == 4'hf)
        else $error("load pin edge did not load dacs");
    track_a_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && src_ctrl_ff[5] |=> o_dac_a_value == $past(i_int_temp_code))
        else $error("first dac not tracking temperature");
endmodule

/* tb/cdu_conv_model.sv */
// Purpose: converter model answering each start with a done pulse
// Assumes: one conversion in flight at a time
// Notes: answer delay is a parameter
`timescale 1ns/1ps
module cdu_conv_model #(parameter int DLY = 3) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // handshake
    input wire logic i_start,
    output logic o_done
);
    int cnt_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt_ff == 1);
            if (i_start)
                cnt_ff <= DLY;
            else if (cnt_ff != 0)
                cnt_ff <= cnt_ff - 1;
        end
    end
endmodule

/* tb/cdu_bank_tb.sv */
// Purpose: self-checking bench of the configuration bank
// Assumes: shortened divider and timeout counts
// Notes: registers reached with one-cycle strobes
`timescale 1ns/1ps
module cdu_bank_tb;
    logic clk = 0, rst = 1, we = 0, re = 0, scl = 1, ldn = 1, mon = 0;
    logic [1:0] pair = 2'h0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, va, vb;
    logic [7:0] tint = 8'h5a, text = 8'ha5;
    logic [3:0] ld, rng;
    logic [2:0] ch;
    logic st, sto, ext, done, rel, srst, fst, flt, rvd, avg;
    localparam int TMO = 50;
    logic ce = 1;
    int err_total = 0, checks_done = 0, n, k, j;
    logic [7:0] ma [4] = '{8'h11, 8'h13, 8'h17, 8'h1c};
    logic [3:0] me [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
    logic [2:0] rr_exp [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    always #4 clk = ~clk;
    cdu_bank #(.SLOW_DIV(20), .FAST_DIV(5), .SCL_TMO(TMO)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_wr_en(we), .i_rd_en(re),
        .i_addr(addr), .i_wdata(wd), .o_rdata(rd), .i_monitor_en(mon),
        .i_pair_sel(pair), .i_dac_load_strobe_n(ldn), .i_scl(scl),
        .o_scl_release(rel), .i_conv_done(done), .o_conv_start(st),
        .o_conv_chan(ch), .o_conv_ext_temp(ext), .o_result_store(sto),
        .o_avg_disable(avg), .o_fast_clk(fst), .o_filter_off(flt),
        .o_ref_vdd(rvd), .o_dac_range(rng), .o_soft_reset(srst),
        .i_dac_a_code(8'h11), .i_dac_b_code(8'h22), .i_int_temp_code(tint),
        .i_ext_temp_code(text), .o_dac_a_value(va), .o_dac_b_value(vb),
        .o_dac_load(ld));
    cdu_conv_model u_conv (.i_clk(clk), .i_rst(rst), .i_start(st),
        .o_done(done));
    task automatic chk(input string nm, input logic [7:0] e, s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, e);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk("rdata", e, rd);
    endtask
    // counts conversion starts until a stored result or the limit
    task automatic starts(input int lim);
        k = 0;
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            #1;
            if (st === 1'b1) k++;
            if (sto === 1'b1) break;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h19, 8'h00);
        rdchk(8'h1a, 8'h00);
        rdchk(8'h1b, 8'h00);
        wr(8'h1b, 8'h3f);
        rdchk(8'h1b, 8'h3f);
        chk("range", 8'h0f, {4'h0, rng});
        // writes are dropped while the clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h1b, 8'h05);
        @(posedge clk);
        ce <= 1'b1;
        rdchk(8'h1b, 8'h3f);
        chk("range_hold", 8'h0f, {4'h0, rng});
        wr(8'h1a, 8'h79);
        repeat (2) @(posedge clk);
        #1;
        chk("speed_ref", 8'h07, {5'h0, fst, flt, rvd});
        chk("dac_a", tint, va);
        chk("dac_b", text, vb);
        foreach (ma[i]) begin
            wr(8'h1b, {2'h0, 2'(i), 4'h0});
            wr(ma[i], 8'h0f);
            chk("load", {4'h0, me[i]}, {4'h0, ld});
        end
        wr(8'h17, 8'h0f);
        chk("load_m3", 8'h00, {4'h0, ld});
        wr(8'h1a, 8'h00);
        @(posedge clk);
        ldn <= 1'b0;
        @(posedge clk);
        #1;
        chk("pin_load", {4'h0, cdu_pkg::LD_ALL}, {4'h0, ld});
        wr(8'h19, 8'h40);
        @(posedge clk);
        scl <= 1'b0;
        for (n = 0; n < 80 && rel !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("tmo", 8'(TMO), 8'(n));
        @(posedge clk);
        scl <= 1'b1;
        @(posedge clk);
        #1;
        chk("tmo_drop", 8'h00, {7'h0, rel});
        wr(8'h1b, 8'h3f);
        wr(8'h1a, 8'h20);
        wr(8'h19, 8'h80);
        chk("soft_pulse", 8'h01, {7'h0, srst});
        rdchk(8'h19, 8'h00);
        rdchk(8'h1a, 8'h00);
        rdchk(8'h1b, 8'h00);
        chk("dac_a_code", 8'h11, va);
        // round robin skips the shared input while the diode is chosen
        wr(8'h19, 8'h20);
        @(posedge clk);
        mon <= 1'b1;
        pair <= cdu_pkg::PAIR_EXT_TEMP;
        for (j = 0; j < 5; j++) begin
            starts(100);
            chk("rr_store", 8'h01, 8'(n < 100));
            chk("rr_chan", {5'h0, rr_exp[j]}, {5'h0, ch});
            chk("rr_ext", 8'(rr_exp[j] == 3'h2), {7'h0, ext});
        end
        @(posedge clk);
        mon <= 1'b0;
        wr(8'h19, 8'h32);
        chk("avg_off", 8'h01, {7'h0, avg});
        @(posedge clk);
        mon <= 1'b1;
        starts(400);
        chk("store", 8'h01, 8'(n < 400));
        chk("chan", 8'h02, {5'h0, ch});
        chk("ext", 8'h01, {7'h0, ext});
        wr(8'h19, 8'h12);
        starts(2000);
        chk("avg_count", 8'(cdu_pkg::AVG_CONV), 8'(k));
        wr(8'h19, 8'h16);
        starts(200);
        chk("reserved", 8'h00, 8'(k));
        chk("no_store", 8'h00, 8'(n < 200));
        complete_run;
    end
endmodule
